// ### design/ptc_top.sv
// Paper-tape reader status and punch control, AHB-Lite slave.
// Assumes one hclk domain; mechanism pins are asynchronous.
// Summary of operation
// - Tape absent blocks read command start
// - No tape keeps a clear run flag clear
// - Feed-hole falling edge triggers presence timer
// - Reader disabled holds timer triggered
// - Read sets run, enable, clock, arm
// - Motor step 2 us after clock
// - Armed timer retriggers on trailing edges
// - Continuous edges every 3.34 ms retrigger
// - Missing read command clears reader enable
// - Stop with hole low rearms hold
// - Timer expires 8.5 ms, tape absent
// - Run-out strobes load all ones
// - Fire pulse on feed switch or punch
// - Punch run waits cycle sync pulse
// - Fire pulse lasts 10 ms
// - Punch buffer loads data, drives holes
// - Buffer holds until next punch/feed
// - Timer end clears run, sets ready
// - Ready with interrupt enable raises request
// - No read before clock clears enable
`include "ptc_defs.svh"
module ptc_top #(
  parameter int TAPE_CYC = `PTC_TAPE_TIMEOUT_CYC,
  parameter int FIRE_CYC = `PTC_FIRE_CYC,
  parameter int CHAR_CYC = `PTC_CHAR_CYC
) (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic feed_hole_sense, // Feed hole pin
  input wire logic punch_cycle_sync, // Punch cycle pin
  input wire logic feed_switch, // Manual punch feed pin
  output logic tape_absent, // No tape
  output logic tape_present, // Tape loaded
  output logic reader_enable, // Reader enable
  output logic motor_step_pulse, // Motor step
  output logic reader_load_strobe, // Reader buffer load
  output logic punch_fire_pulse, // Solenoid enable
  output logic [8:1] punch_hole_lines, // Punch data
  output logic bus_interrupt_request // Interrupt
);
  ptc_pkg::ptc_state_s q, d;
  logic take, fh_fall, ps_rise, fs_rise, rd_cmd, punch_cmd, char_clk;

  always_comb
  begin
    d = q;
    take = hsel && hready && htrans[1];
    fh_fall = q.fh3 && !q.fh2;
    ps_rise = q.ps2 && !q.ps3;
    fs_rise = q.fs2 && !q.fs3;
    rd_cmd = q.wr_pend && q.addr == `PTC_A_CMD && hwdata[`PTC_B_RD];
    punch_cmd = q.wr_pend && q.addr == `PTC_A_PUNCH;
    d.fh2 = q.fh1;
    d.fh3 = q.fh2;
    d.ps2 = q.ps1;
    d.ps3 = q.ps2;
    d.fs2 = q.fs1;
    d.fs3 = q.fs2;
    d.fh1 = feed_hole_sense;
    d.ps1 = punch_cycle_sync;
    d.fs1 = feed_switch;
    d.clk_pulse = 1'b0;
    d.load_strobe = 1'b0;
    d.step = 1'b0;
    // Bus slave: zero wait state
    d.wr_pend = take && hwrite;
    d.hreadyout = 1'b1;
    if (take)
      d.addr = {haddr[31:2], 2'b00};
    if (take && !hwrite)
    begin
      case ({haddr[31:2], 2'b00})
        `PTC_A_CTRL: d.hrdata = {30'h0, q.feed_sw, q.int_en};
        `PTC_A_STAT: d.hrdata = {23'h0, q.syncrq, q.fire, q.pflag, q.prun, q.arm, q.ena, q.run,
                                 q.timer_on, !q.timer_on};
        `PTC_A_PUNCH: d.hrdata = {24'h0, q.pbuf};
        default: d.hrdata = 32'h0;
      endcase
    end
    if (q.wr_pend && q.addr == `PTC_A_CTRL)
    begin
      d.int_en = hwdata[`PTC_B_INTEN];
    end
    // Reader: read command only starts with tape present
    if (rd_cmd && q.timer_on)
      d.run = 1'b1;
    if (q.run && !q.ena)
    begin
      d.ena = 1'b1;
      d.clk_pulse = 1'b1;
      d.ccnt = `PTC_CNT_W'(CHAR_CYC);
      d.scnt = `PTC_STEP_W'(`PTC_STEP_DLY_CYC);
      d.step_pend = 1'b1;
    end
    if (q.step_pend)
    begin
      if (q.scnt <= `PTC_STEP_W'(1))
      begin
        d.step = 1'b1;
        d.step_pend = 1'b0;
      end
      else
        d.scnt = q.scnt - `PTC_STEP_W'(1);
    end
    if (q.ena)
    begin
      if (q.ccnt <= `PTC_CNT_W'(1))
      begin
        // Character time: strobe loads buffer, run clears unless a read command arrives with tape present
        d.load_strobe = 1'b1;
        d.run = rd_cmd && q.timer_on;
        if (!q.run && !rd_cmd)
          d.ena = 1'b0;
        else
        begin
          d.clk_pulse = 1'b1;
          d.ccnt = `PTC_CNT_W'(CHAR_CYC);
          d.scnt = `PTC_STEP_W'(`PTC_STEP_DLY_CYC);
          d.step_pend = 1'b1;
        end
      end
      else
        d.ccnt = q.ccnt - `PTC_CNT_W'(1);
      if (!q.timer_on)
        d.ena = 1'b0;
    end
    // Presence timer
    d.arm = q.ena && (q.arm || q.clk_pulse);
    if (fh_fall)
    begin
      d.timer_on = 1'b1;
      d.tcnt = `PTC_CNT_W'(TAPE_CYC);
    end
    else if (!q.arm && q.timer_on)
      d.tcnt = `PTC_CNT_W'(TAPE_CYC);
    else if (q.timer_on)
    begin
      if (q.tcnt <= `PTC_CNT_W'(1))
        d.timer_on = 1'b0;
      else
        d.tcnt = q.tcnt - `PTC_CNT_W'(1);
    end
    // Punch path
    d.feed_sw = q.fs3;
    if (punch_cmd)
    begin
      d.pbuf = hwdata[7:0];
      d.prun = 1'b1;
      d.syncrq = 1'b1;
      d.pflag = 1'b0;
    end
    if (q.wr_pend && q.addr == `PTC_A_CMD && hwdata[`PTC_B_CLRFLAG])
      d.pflag = 1'b0;
    if (fs_rise && !q.fire)
    begin
      d.pbuf = 8'h00;
      d.fire = 1'b1;
      d.fcnt = `PTC_CNT_W'(FIRE_CYC);
    end
    if (q.syncrq && ps_rise && !q.fire)
    begin
      d.syncrq = 1'b0;
      d.fire = 1'b1;
      d.fcnt = `PTC_CNT_W'(FIRE_CYC);
    end
    else if (q.fire)
    begin
      if (q.fcnt <= `PTC_CNT_W'(1))
      begin
        d.fire = 1'b0;
        if (q.prun)
        begin
          d.prun = 1'b0;
          d.pflag = 1'b1;
        end
      end
      else
        d.fcnt = q.fcnt - `PTC_CNT_W'(1);
    end
    d.irq = d.pflag && d.int_en;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.hreadyout <= 1'b1;
      q.fh1 <= 1'b1;
      q.fh2 <= 1'b1;
      q.fh3 <= 1'b1;
    end
    else
      q <= d;
  end

  always_comb
  begin
    hrdata = q.hrdata;
    hreadyout = q.hreadyout;
    hresp = 1'b0;
    tape_absent = !q.timer_on;
    tape_present = q.timer_on;
    reader_enable = q.ena;
    motor_step_pulse = q.step;
    reader_load_strobe = q.load_strobe;
    punch_fire_pulse = q.fire;
    punch_hole_lines = q.pbuf;
    bus_interrupt_request = q.irq;
  end

  AST_ABSENT_BLOCKS: assert property (@(posedge hclk) disable iff (!hresetn)
    !q.timer_on && !q.run |=> !q.run) else $error("run set without tape");
  AST_STEP_DELAY: assert property (@(posedge hclk) disable iff (!hresetn)
    q.clk_pulse |-> ##[1:120] q.step) else $error("step late");
  AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !q.arm && q.timer_on |=> q.timer_on) else $error("timer lost while held");
  AST_RETRIG: assert property (@(posedge hclk) disable iff (!hresetn)
    fh_fall |=> q.timer_on && q.tcnt == `PTC_CNT_W'(TAPE_CYC)) else $error("no retrigger");
  AST_ARM: assert property (@(posedge hclk) disable iff (!hresetn)
    !q.ena |=> !q.arm) else $error("arm without enable");
  AST_FIRE_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(q.fire) |-> q.fcnt == `PTC_CNT_W'(FIRE_CYC)) else $error("fire length");
  AST_READY: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(q.prun) |-> q.pflag) else $error("ready not set");
  AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    q.pflag && q.int_en |-> q.irq) else $error("irq missing");
  AST_BUF: assert property (@(posedge hclk) disable iff (!hresetn)
    punch_cmd |=> q.pbuf == $past(hwdata[7:0])) else $error("buffer load");
endmodule : ptc_top

// ### design/ptc_defs.svh
// Constants for the paper-tape status and punch control block.
// Assumes a 50 MHz hclk; times are kept in their own units.
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH
`define PTC_CLK_MHZ 50
`define PTC_TAPE_TIMEOUT_US 8500
`define PTC_TAPE_TIMEOUT_CYC (`PTC_TAPE_TIMEOUT_US * `PTC_CLK_MHZ)
`define PTC_FIRE_US 10000
`define PTC_FIRE_CYC (`PTC_FIRE_US * `PTC_CLK_MHZ)
`define PTC_STEP_DLY_US 2
`define PTC_STEP_DLY_CYC (`PTC_STEP_DLY_US * `PTC_CLK_MHZ)
`define PTC_CHAR_US 3340
`define PTC_CHAR_CYC (`PTC_CHAR_US * `PTC_CLK_MHZ)
`define PTC_CNT_W 20
`define PTC_STEP_W 8
`define PTC_A_CTRL 32'h0000_0000
`define PTC_A_STAT 32'h0000_0004
`define PTC_A_PUNCH 32'h0000_0008
`define PTC_A_CMD 32'h0000_000c
`define PTC_B_INTEN 0
`define PTC_B_FEEDSW 1
`define PTC_B_RD 0
`define PTC_B_CLRFLAG 1
`define PTC_ST_ABSENT 0
`define PTC_ST_PRESENT 1
`define PTC_ST_RUN 2
`define PTC_ST_ENA 3
`define PTC_ST_ARM 4
`define PTC_ST_PRUN 5
`define PTC_ST_PFLAG 6
`define PTC_ST_FIRE 7
`define PTC_ST_SYNCRQ 8
`endif

// ### design/ptc_pkg.sv
// Types for the paper-tape status and punch control block.
// Assumes ptc_defs.svh for widths.
`include "ptc_defs.svh"
package ptc_pkg;
  typedef enum logic [1:0] {PTC_IDLE = 2'b00, PTC_ADDR = 2'b01, PTC_DATA = 2'b11} ptc_bus_e;
  typedef logic [`PTC_CNT_W-1:0] ptc_cnt_t;
  typedef struct packed {
    logic hreadyout;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [31:0] addr;
    logic int_en;
    logic feed_sw;
    logic run;
    logic ena;
    logic arm;
    logic timer_on;
    ptc_cnt_t tcnt;
    ptc_cnt_t ccnt;
    logic [`PTC_STEP_W-1:0] scnt;
    logic step_pend;
    logic step;
    logic clk_pulse;
    logic load_strobe;
    logic [7:0] pbuf;
    logic prun;
    logic syncrq;
    logic fire;
    ptc_cnt_t fcnt;
    logic pflag;
    logic irq;
    logic fh1, fh2, fh3;
    logic ps1, ps2, ps3;
    logic fs1, fs2, fs3;
  } ptc_state_s;
endpackage : ptc_pkg

// ### dv/ptc_mech.sv
// Reader/punch mechanism model: feed-hole sensor, punch sync, feed switch.
// Assumes one hclk domain; a step pulse moves one feed hole past the sensor.
module ptc_mech (
  input wire logic hclk, // Clock
  input wire logic tape_in, // Tape loaded
  input wire logic feed_req, // Manual feed request
  input wire logic motor_step_pulse, // Motor step
  output logic feed_hole_sense, // High on hole or no tape
  output logic punch_cycle_sync, // Once per revolution
  output logic feed_switch // Feed switch level
);
  timeunit 1ns;
  timeprecision 1ns;
  int hole = 0;
  int rev = 0;
  always @(posedge hclk)
  begin
    hole <= motor_step_pulse ? 20 : (hole > 0 ? hole - 1 : 0);
    rev <= (rev == 39) ? 0 : rev + 1;
    feed_switch <= feed_req;
  end
  // No web in the feeder reads as a hole
  assign feed_hole_sense = !tape_in || hole > 0;
  assign punch_cycle_sync = rev < 3;
endmodule : ptc_mech

// ### dv/test_paper_tape_status_and_punch_ctl.sv
// Self-checking bench for ptc_top over AHB-Lite with a mechanism model.
// Assumes shortened one-shot counts: 400 tape, 50 fire and 150 character cycles.
module test_paper_tape_status_and_punch_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TAPE = 400;
  localparam int FIRE = 50;
  localparam int CHR = 150;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic tape_in = 1'b0;
  logic feed_req = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, d, seed = 32'h0000_4fe4;
  logic [31:0] hrdata;
  logic hreadyout, hresp, feed_hole_sense, punch_cycle_sync, feed_switch, tape_absent, tape_present;
  logic reader_enable, motor_step_pulse, reader_load_strobe, punch_fire_pulse, bus_interrupt_request;
  logic [8:1] punch_hole_lines;
  int n_errors = 0, checks_done = 0, n_step = 0, n_fire = 0, n_load = 0, st, f;
  ptc_top #(.TAPE_CYC(TAPE), .FIRE_CYC(FIRE), .CHAR_CYC(CHR)) ptc_top_i (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .feed_hole_sense,
    .punch_cycle_sync, .feed_switch, .tape_absent, .tape_present, .reader_enable, .motor_step_pulse,
    .reader_load_strobe, .punch_fire_pulse, .punch_hole_lines, .bus_interrupt_request);
  ptc_mech ptc_mech_i (.hclk, .tape_in, .feed_req, .motor_step_pulse, .feed_hole_sense, .punch_cycle_sync,
    .feed_switch);
  initial forever #10 hclk = ~hclk;
  always @(posedge hclk)
  begin
    n_step <= n_step + int'(motor_step_pulse === 1'b1);
    n_fire <= n_fire + int'(punch_fire_pulse === 1'b1);
    n_load <= n_load + int'(reader_load_strobe === 1'b1);
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    cyc(30000);
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    cyc(16);
    hresetn <= 1'b1;
    cyc(1);
    bus(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h1);
    chk({hresp, hreadyout}, 32'h1);
    bus(1'b1, 32'hc, 32'h1);
    cyc(10);
    chk(reader_enable, 32'h0);
    tape_in <= 1'b1;
    cyc(TAPE + 50);
    chk({tape_absent, tape_present}, 32'h1);
    bus(1'b1, 32'hc, 32'h1);
    cyc(10);
    chk(reader_enable, 32'h1);
    st = n_step;
    repeat (25)
    begin
      bus(1'b1, 32'hc, 32'h1);
      cyc(60);
    end
    chk(n_step - st >= 5, 32'h1);
    chk({reader_enable, tape_present}, 32'h3);
    cyc(2 * CHR + 60);
    chk(reader_enable, 32'h0);
    cyc(TAPE + 50);
    chk(tape_present, 32'h1);
    bus(1'b1, 32'hc, 32'h1);
    tape_in <= 1'b0;
    st = n_load;
    repeat (20)
    begin
      bus(1'b1, 32'hc, 32'h1);
      cyc(60);
    end
    chk({tape_absent, reader_enable}, 32'h2);
    chk(n_load - st >= 2, 32'h1);
    bus(1'b1, 32'h0, 32'h1);
    repeat (3)
    begin
      d = xs() & 32'hff;
      f = n_fire;
      bus(1'b1, 32'h8, d);
      cyc(2);
      chk(punch_hole_lines, d);
      cyc(FIRE + 60);
      chk(n_fire - f, FIRE);
      bus(1'b0, 32'h8, 32'h0);
      chk(rd, d);
      bus(1'b0, 32'h4, 32'h0);
      chk(rd[6], 32'h1);
      chk(bus_interrupt_request, 32'h1);
      bus(1'b1, 32'hc, 32'h2);
      cyc(2);
      chk(bus_interrupt_request, 32'h0);
    end
    f = n_fire;
    feed_req <= 1'b1;
    cyc(FIRE + 60);
    feed_req <= 1'b0;
    chk(n_fire - f, FIRE);
    chk(punch_hole_lines, 32'h0);
    tally_and_finish();
  end
endmodule : test_paper_tape_status_and_punch_ctl
